// File: core/hsr_pkg.sv
// Constants and types shared by the high-speed reading mode controller
package hsr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] HSR_REG_CTRL = 4'h0;
  localparam logic [3:0] HSR_REG_CONFIG = 4'h1;
  localparam logic [3:0] HSR_REG_COUNT = 4'h2;
  localparam logic [3:0] HSR_REG_ARM = 4'h3;
  localparam logic [3:0] HSR_REG_STATUS = 4'h4;
  localparam logic [3:0] HSR_REG_DONE = 4'h5;
  // CTRL bits (write-one actions)
  localparam int HSR_CTRL_START = 0;
  localparam int HSR_CTRL_PRESET_FAST = 1;
  // CONFIG field positions
  localparam int HSR_CFG_FUNC_LSB = 0;
  localparam int HSR_CFG_PLC_LSB = 3;
  localparam int HSR_CFG_AUTORANGE = 8;
  localparam int HSR_CFG_DISPLAY = 9;
  localparam int HSR_CFG_MATH = 10;
  localparam int HSR_CFG_MEM_EN = 11;
  localparam int HSR_CFG_MEM_LIFO = 12;
  localparam int HSR_CFG_MFMT_LSB = 13;
  localparam int HSR_CFG_OFMT_LSB = 15;
  localparam int HSR_CFG_EOI_ALWAYS = 17;
  localparam int HSR_CFG_INBUF_EN = 18;
  // Function codes; all but HSR_FUNC_OTHER are eligible for fast mode
  localparam logic [2:0] HSR_FUNC_DCV = 3'h0;
  localparam logic [2:0] HSR_FUNC_DCI = 3'h1;
  localparam logic [2:0] HSR_FUNC_OHM2 = 3'h2;
  localparam logic [2:0] HSR_FUNC_OHM4 = 3'h3;
  localparam logic [2:0] HSR_FUNC_SAMPLED = 3'h4;
  localparam logic [2:0] HSR_FUNC_OTHER = 3'h5;
  // Formats
  localparam logic [1:0] HSR_FMT_ASCII = 2'h0;
  localparam logic [1:0] HSR_FMT_SINGLE_INT = 2'h1;
  localparam logic [1:0] HSR_FMT_DOUBLE_INT = 2'h2;
  localparam logic [1:0] HSR_FMT_REAL = 2'h3;
  // Integration time in power line cycles, fast mode below this
  localparam logic [4:0] HSR_PLC_LIMIT = 5'h0a;
  // Trigger arm event codes
  localparam logic [1:0] HSR_ARM_AUTO = 2'h0;
  localparam logic [1:0] HSR_ARM_HOLD = 2'h1;
  // Reset values
  localparam logic [18:0] HSR_CONFIG_RST = 19'h40000;
  localparam logic [15:0] HSR_COUNT_RST = 16'h0001;
  localparam int HSR_MEM_DEPTH = 16;
  localparam int HSR_MEM_AW = 4;
  typedef enum logic [1:0] {HSR_IDLE, HSR_NORMAL, HSR_FAST} hsr_state_e;
endpackage

// File: core/hsr_mem.sv
// Reading memory with FIFO and LIFO full behaviour
`timescale 1ns/10ps
module hsr_mem (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic lifo_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic full_o,
  output logic [hsr_pkg::HSR_MEM_AW:0] level_o
);
  import hsr_pkg::*;
  logic [31:0] mem_r [HSR_MEM_DEPTH];
  logic [HSR_MEM_AW-1:0] wp_r;
  logic [HSR_MEM_AW-1:0] rp_r;
  logic [HSR_MEM_AW:0] cnt_r;
  logic do_wr;
  logic do_rd;
  logic drop_old;

  // ---------------------------------------------------------------
  // Access qualification
  // ---------------------------------------------------------------
  assign full_o = (cnt_r == HSR_MEM_DEPTH[HSR_MEM_AW:0]);
  assign do_rd = rd_i && (cnt_r != '0);
  assign drop_old = wr_i && full_o && lifo_i && !do_rd;
  assign do_wr = wr_i && (!full_o || lifo_i || do_rd);
  assign level_o = cnt_r;

  // Storage
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem_r[wp_r] <= wdata_i;
    end
  end

  // Pointers and fill count; a full LIFO write pushes out the oldest
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd || drop_old) begin
        rp_r <= rp_r + 1'b1;
      end
      if (do_wr && !do_rd && !drop_old) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // Read data registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (do_rd) begin
      rdata_o <= mem_r[rp_r];
    end
  end

  chk_lifo_no_grow: assert property (@(posedge clock_i) disable iff (reset_i)
    drop_old |=> cnt_r == HSR_MEM_DEPTH[HSR_MEM_AW:0])
    else $error("lifo full write changed level");
endmodule

// File: core/hsr_ctrl.sv
// High-speed reading mode controller top
`timescale 1ns/10ps
module hsr_ctrl (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic rdg_valid_i,
  input wire logic [31:0] rdg_data_i,
  output logic rdg_ready_o,
  output logic meas_run_o,
  input wire logic bus_cmd_valid_i,
  output logic bus_cmd_accept_o,
  input wire logic dev_clear_i,
  output logic [31:0] out_data_o,
  output logic out_full_o,
  output logic out_eoi_o,
  input wire logic out_take_i,
  input wire logic mem_read_i,
  output logic [31:0] mem_data_o,
  output logic fast_mode_o,
  output logic inbuf_enable_o,
  output logic eoi_always_o
);
  import hsr_pkg::*;
  hsr_state_e state_r;
  logic [18:0] config_r;
  logic [15:0] count_r;
  logic [15:0] done_r;
  logic [1:0] arm_r;
  logic [2:0] func;
  logic [4:0] power_line_cycle;
  logic mem_en;
  logic [1:0] mfmt;
  logic [1:0] ofmt;
  logic func_ok;
  logic fmt_ok;
  logic fast_ok;
  logic start_req;
  logic preset_req;
  logic in_run;
  logic fast;
  logic mem_full;
  logic [HSR_MEM_AW:0] mem_level;
  logic take_rdg;
  logic last_rdg;
  logic fifo_stop;
  logic out_free;
  logic arm_wr;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  assign func = config_r[HSR_CFG_FUNC_LSB +: 3];
  assign power_line_cycle = config_r[HSR_CFG_PLC_LSB +: 5];
  assign mem_en = config_r[HSR_CFG_MEM_EN];
  assign mfmt = config_r[HSR_CFG_MFMT_LSB +: 2];
  assign ofmt = config_r[HSR_CFG_OFMT_LSB +: 2];
  assign func_ok = (func == HSR_FUNC_DCV) || (func == HSR_FUNC_DCI) ||
                   (func == HSR_FUNC_OHM2) || (func == HSR_FUNC_OHM4) ||
                   (func == HSR_FUNC_SAMPLED);
  // Integer format needed on memory when enabled, else on the bus
  assign fmt_ok = mem_en ?
    (mfmt == HSR_FMT_SINGLE_INT || mfmt == HSR_FMT_DOUBLE_INT) :
    (ofmt == HSR_FMT_SINGLE_INT || ofmt == HSR_FMT_DOUBLE_INT);
  assign fast_ok = func_ok && (power_line_cycle < HSR_PLC_LIMIT) && !config_r[HSR_CFG_AUTORANGE] &&
                   !config_r[HSR_CFG_DISPLAY] && !config_r[HSR_CFG_MATH] &&
                   fmt_ok;

  // ---------------------------------------------------------------
  // Bus access; commands are locked out while fast readings run
  // ---------------------------------------------------------------
  assign fast = (state_r == HSR_FAST);
  assign in_run = (state_r != HSR_IDLE);
  assign bus_cmd_accept_o = bus_cmd_valid_i && !fast;
  assign start_req = reg_wr_i && !fast && (reg_addr_i == HSR_REG_CTRL) &&
                     reg_wdata_i[HSR_CTRL_START] && (arm_r != HSR_ARM_HOLD);
  assign preset_req = reg_wr_i && !fast && (reg_addr_i == HSR_REG_CTRL) &&
                      reg_wdata_i[HSR_CTRL_PRESET_FAST];
  assign arm_wr = reg_wr_i && !fast && (reg_addr_i == HSR_REG_ARM);

  // Configuration register; fast preset clears the slow features
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      config_r <= HSR_CONFIG_RST;
    end else if (reg_wr_i && !fast && reg_addr_i == HSR_REG_CONFIG) begin
      config_r <= reg_wdata_i[18:0];
    end else if (preset_req) begin
      config_r[HSR_CFG_AUTORANGE] <= 1'b0;
      config_r[HSR_CFG_DISPLAY] <= 1'b0;
      config_r[HSR_CFG_MATH] <= 1'b0;
      config_r[HSR_CFG_MFMT_LSB +: 2] <= HSR_FMT_DOUBLE_INT;
      config_r[HSR_CFG_OFMT_LSB +: 2] <= HSR_FMT_DOUBLE_INT;
    end
  end

  // Requested reading count
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_r <= HSR_COUNT_RST;
    end else if (reg_wr_i && !fast && reg_addr_i == HSR_REG_COUNT) begin
      count_r <= reg_wdata_i[15:0];
    end
  end

  // Trigger arm event; full FIFO memory in fast mode forces hold, host rewrites it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      arm_r <= HSR_ARM_AUTO;
    end else if (fifo_stop) begin
      arm_r <= HSR_ARM_HOLD;
    end else if (arm_wr) begin
      arm_r <= reg_wdata_i[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Reading sequence
  // ---------------------------------------------------------------
  assign out_free = !out_full_o || out_take_i;
  // Fast bus-only path waits for the host; a full FIFO memory stops intake in fast mode
  assign rdg_ready_o = in_run &&
                       !(fast && mem_en && !config_r[HSR_CFG_MEM_LIFO] && mem_full) &&
                       (!(fast && !mem_en) || out_free);
  assign take_rdg = rdg_valid_i && rdg_ready_o;
  assign last_rdg = take_rdg && (done_r + 16'h0001 >= count_r);
  assign fifo_stop = fast && mem_en && !config_r[HSR_CFG_MEM_LIFO] &&
                     mem_full && rdg_valid_i;
  assign meas_run_o = in_run;

  // Mode state
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_r <= HSR_IDLE;
    end else if (dev_clear_i) begin
      state_r <= HSR_IDLE;
    end else begin
      unique case (state_r)
        HSR_IDLE: begin
          if (start_req) begin
            state_r <= fast_ok ? HSR_FAST : HSR_NORMAL;
          end
        end
        HSR_NORMAL: begin
          if (last_rdg) begin
            state_r <= HSR_IDLE;
          end
        end
        HSR_FAST: begin
          if (last_rdg || fifo_stop) begin
            state_r <= HSR_IDLE;
          end
        end
      endcase
    end
  end

  // Readings delivered so far
  always_ff @(posedge clock_i) begin
    if (reset_i || start_req) begin
      done_r <= '0;
    end else if (take_rdg) begin
      done_r <= done_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Output buffer toward the host
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i || dev_clear_i) begin
      out_full_o <= 1'b0;
      out_data_o <= '0;
      out_eoi_o <= 1'b0;
    end else if (take_rdg && !mem_en) begin
      out_full_o <= 1'b1;
      out_data_o <= rdg_data_i;
      // End of transfer only while fast, else per user setting
      out_eoi_o <= (fast && config_r[HSR_CFG_EOI_ALWAYS]) ? last_rdg :
                   (config_r[HSR_CFG_EOI_ALWAYS] || last_rdg);
    end else if (out_take_i) begin
      out_full_o <= 1'b0;
    end
  end

  // Effective settings, user choice back once fast readings end
  assign inbuf_enable_o = config_r[HSR_CFG_INBUF_EN] && !fast;
  assign eoi_always_o = config_r[HSR_CFG_EOI_ALWAYS] && !fast;
  assign fast_mode_o = fast;

  // ---------------------------------------------------------------
  // Reading memory
  // ---------------------------------------------------------------
  hsr_mem u_mem (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .lifo_i(config_r[HSR_CFG_MEM_LIFO]),
    .wr_i(take_rdg && mem_en),
    .wdata_i(rdg_data_i),
    .rd_i(mem_read_i && !fast),
    .rdata_o(mem_data_o),
    .full_o(mem_full),
    .level_o(mem_level)
  );

  // Register read port
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        HSR_REG_CONFIG: reg_rdata_o <= {13'h0000, config_r};
        HSR_REG_COUNT: reg_rdata_o <= {16'h0000, count_r};
        HSR_REG_ARM: reg_rdata_o <= {30'h00000000, arm_r};
        HSR_REG_STATUS: reg_rdata_o <= {22'h000000, mem_level, mem_full,
                                        state_r, out_full_o, fast};
        HSR_REG_DONE: reg_rdata_o <= {16'h0000, done_r};
        default: reg_rdata_o <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_cmd_locked: assert property (@(posedge clock_i) disable iff (reset_i)
    fast |-> !bus_cmd_accept_o)
    else $error("command accepted in fast mode");
  chk_hold_back: assert property (@(posedge clock_i) disable iff (reset_i)
    (fast && !mem_en && out_full_o && !out_take_i) |-> !rdg_ready_o)
    else $error("reading overwrote unread fast output");
  chk_normal_over: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_r == HSR_NORMAL && !mem_en && rdg_valid_i) |-> rdg_ready_o)
    else $error("normal mode stalled reading");
  chk_fifo_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    fifo_stop && !dev_clear_i |=> arm_r == HSR_ARM_HOLD && state_r == HSR_IDLE)
    else $error("fifo full did not stop");
  chk_clear_exit: assert property (@(posedge clock_i) disable iff (reset_i)
    dev_clear_i |=> !fast_mode_o && !out_full_o)
    else $error("device clear did not exit");
  chk_last_exit: assert property (@(posedge clock_i) disable iff (reset_i)
    (fast && last_rdg) |=> state_r == HSR_IDLE)
    else $error("fast mode outlived count");
  chk_inbuf_off: assert property (@(posedge clock_i) disable iff (reset_i)
    fast |-> !inbuf_enable_o && !eoi_always_o)
    else $error("input buffer open in fast mode");
  chk_restore: assert property (@(posedge clock_i) disable iff (reset_i)
    $fell(fast) |-> inbuf_enable_o == config_r[HSR_CFG_INBUF_EN])
    else $error("settings not restored");
  chk_entry: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_r == HSR_IDLE && start_req && fast_ok && !dev_clear_i) |=> fast)
    else $error("fast mode not entered");

  // Entry, exit and resume
  chk_entry_slow: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_r == HSR_IDLE && start_req && !fast_ok && !dev_clear_i) |=> state_r == HSR_NORMAL)
    else $error("slow start did not run normal");
  chk_normal_exit: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_r == HSR_NORMAL && last_rdg && !dev_clear_i) |=> state_r == HSR_IDLE)
    else $error("normal run outlived count");
  chk_start_blocked: assert property (@(posedge clock_i) disable iff (reset_i)
    (state_r == HSR_IDLE && arm_r == HSR_ARM_HOLD) |=> state_r == HSR_IDLE)
    else $error("started while arm held");
  chk_done_count: assert property (@(posedge clock_i) disable iff (reset_i)
    (take_rdg && !start_req) |=> done_r == $past(done_r) + 16'h0001)
    else $error("delivered count wrong");

  // Lockout of settings while fast readings run
  chk_cfg_frozen: assert property (@(posedge clock_i) disable iff (reset_i)
    fast |=> $stable(config_r))
    else $error("configuration changed in fast mode");
  chk_count_frozen: assert property (@(posedge clock_i) disable iff (reset_i)
    fast |=> $stable(count_r))
    else $error("count changed in fast mode");
  chk_preset_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    preset_req |=> !config_r[HSR_CFG_AUTORANGE] && !config_r[HSR_CFG_DISPLAY] &&
    !config_r[HSR_CFG_MATH])
    else $error("fast preset left slow feature on");

  // Output buffer
  chk_out_load: assert property (@(posedge clock_i) disable iff (reset_i)
    (take_rdg && !mem_en && !dev_clear_i) |=> out_full_o && out_data_o == $past(rdg_data_i))
    else $error("reading not placed in output");
  chk_out_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    (out_full_o && !out_take_i && !take_rdg && !dev_clear_i) |=> out_full_o)
    else $error("unread output dropped");
  chk_eoi_end_only: assert property (@(posedge clock_i) disable iff (reset_i)
    (fast && take_rdg && !mem_en && !last_rdg && !dev_clear_i) |=> !out_eoi_o)
    else $error("eoi before end of fast transfer");
  chk_eoi_last: assert property (@(posedge clock_i) disable iff (reset_i)
    (take_rdg && !mem_en && last_rdg && !dev_clear_i) |=> out_eoi_o)
    else $error("no eoi on last reading");

  // Reading memory intake
  chk_fifo_no_take: assert property (@(posedge clock_i) disable iff (reset_i)
    (fast && mem_en && !config_r[HSR_CFG_MEM_LIFO] && mem_full) |-> !rdg_ready_o)
    else $error("full fifo took a reading");
  chk_lifo_flow: assert property (@(posedge clock_i) disable iff (reset_i)
    (fast && mem_en && config_r[HSR_CFG_MEM_LIFO] && rdg_valid_i) |-> rdg_ready_o)
    else $error("lifo memory stalled reading");
endmodule

// File: testbench/hsr_host_model.sv
// Host model that removes readings from the output buffer
`timescale 1ns/10ps
module hsr_host_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic [3:0] delay_i,
  input wire logic [31:0] out_data_i,
  input wire logic out_full_i,
  input wire logic out_eoi_i,
  output logic out_take_o
);
  logic [31:0] got_data [8];
  logic got_eoi [8];
  int n_got;
  logic [3:0] wait_r;
  // ----------------------------------------
  // Removal
  // ----------------------------------------
  // Waits a set time, then removes the reading with a one-cycle pulse
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      out_take_o <= 1'b0;
      wait_r <= 4'h0;
      n_got <= 0;
    end else if (out_take_o || !out_full_i || !enable_i) begin
      out_take_o <= 1'b0; // Only a full buffer is ever emptied
      wait_r <= 4'h0;
    end else if (wait_r >= delay_i) begin
      out_take_o <= 1'b1;
      got_data[n_got[2:0]] <= out_data_i;
      got_eoi[n_got[2:0]] <= out_eoi_i;
      n_got <= n_got + 1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// File: testbench/high_speed_reading_mode_ctrl_bench.sv
// Self-checking bench for the high-speed reading mode controller
`timescale 1ns/10ps
module high_speed_reading_mode_ctrl_bench;
  import hsr_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic rdg_valid_i = 1'b0;
  logic [31:0] rdg_data_i = 32'h0;
  logic bus_cmd_valid_i = 1'b0;
  logic dev_clear_i = 1'b0;
  logic mem_read_i = 1'b0;
  logic host_en = 1'b1;
  logic [3:0] host_delay = 4'h0;
  logic out_take_i, rdg_ready_o, meas_run_o, bus_cmd_accept_o, out_full_o, out_eoi_o;
  logic fast_mode_o, inbuf_enable_o, eoi_always_o;
  logic [31:0] reg_rdata_o, out_data_o, mem_data_o, rd;
  int num_errors = 0;
  int total_checks = 0;
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  hsr_ctrl u_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rdg_valid_i(rdg_valid_i), .rdg_data_i(rdg_data_i),
    .rdg_ready_o(rdg_ready_o), .meas_run_o(meas_run_o), .bus_cmd_valid_i(bus_cmd_valid_i),
    .bus_cmd_accept_o(bus_cmd_accept_o), .dev_clear_i(dev_clear_i),
    .out_data_o(out_data_o), .out_full_o(out_full_o), .out_eoi_o(out_eoi_o),
    .out_take_i(out_take_i), .mem_read_i(mem_read_i), .mem_data_o(mem_data_o),
    .fast_mode_o(fast_mode_o), .inbuf_enable_o(inbuf_enable_o), .eoi_always_o(eoi_always_o));
  hsr_host_model u_host (.clock_i(clock_i), .reset_i(reset_i), .enable_i(host_en),
    .delay_i(host_delay), .out_data_i(out_data_o), .out_full_i(out_full_o),
    .out_eoi_i(out_eoi_o), .out_take_o(out_take_i));
  // Clock and watchdog
  initial begin
    forever #2 clock_i = ~clock_i;
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    results();
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic do_reset();
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask
  // Offers one reading and waits a bounded time for it to be taken
  task automatic feed(input logic [31:0] d, output logic taken);
    taken = 1'b0;
    @(posedge clock_i);
    rdg_valid_i <= 1'b1;
    rdg_data_i <= d;
    for (int i = 0; i < 40 && !taken; i++) begin
      @(posedge clock_i);
      taken = rdg_ready_o;
    end
    rdg_valid_i <= 1'b0;
  endtask
  task automatic pulse_clear();
    @(posedge clock_i);
    dev_clear_i <= 1'b1;
    @(posedge clock_i);
    dev_clear_i <= 1'b0;
  endtask
  task automatic pop_mem();
    @(posedge clock_i);
    mem_read_i <= 1'b1;
    @(posedge clock_i);
    mem_read_i <= 1'b0;
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    do_reset();
    #1 check_bit(inbuf_enable_o, 1'b1);
    check_bit(fast_mode_o, 1'b0);
    rd_reg(HSR_REG_CONFIG);
    check(rd, {13'h0, HSR_CONFIG_RST});
    rd_reg(HSR_REG_COUNT);
    check(rd, {16'h0, HSR_COUNT_RST});
    rd_reg(4'hf);
    check(rd, 32'h0);
  endtask
  // Top bit of each entry is whether the setting allows fast mode
  task automatic t_entry();
    logic [32:0] tbl [16] = '{33'h100048000, 33'h100048001, 33'h100048002,
      33'h100048003, 33'h100048004, 33'h048005, 33'h100048048, 33'h048050,
      33'h048100, 33'h048200, 33'h048400, 33'h100050000, 33'h040000,
      33'h100042800, 33'h048800, 33'h100044800};
    logic taken;
    for (int i = 0; i < 16; i++) begin
      do_reset();
      wr(HSR_REG_CONFIG, tbl[i][31:0]);
      wr(HSR_REG_CTRL, 32'h1);
      bus_cmd_valid_i <= 1'b1;
      #1 check_bit(fast_mode_o, tbl[i][32]);
      check_bit(bus_cmd_accept_o, !tbl[i][32]);
      check_bit(inbuf_enable_o, !tbl[i][32]);
      feed(32'(i), taken);
      repeat (8) @(posedge clock_i);
      #1 check_bit(fast_mode_o, 1'b0);
      check_bit(inbuf_enable_o, 1'b1);
      check_bit(bus_cmd_accept_o, 1'b1);
      bus_cmd_valid_i <= 1'b0;
    end
  endtask
  task automatic t_flow();
    logic taken;
    do_reset();
    host_delay <= 4'h6;
    wr(HSR_REG_CONFIG, 32'h68000);
    wr(HSR_REG_COUNT, 32'h3);
    wr(HSR_REG_CTRL, 32'h1);
    #1 check_bit(eoi_always_o, 1'b0);
    feed(32'ha1, taken);
    feed(32'ha2, taken);
    #1 check(32'(u_host.n_got), 32'h1);
    feed(32'ha3, taken);
    repeat (20) @(posedge clock_i);
    #1 check(32'(u_host.n_got), 32'h3);
    for (int k = 0; k < 3; k++) begin
      check(u_host.got_data[k], 32'(32'ha1 + k));
      check_bit(u_host.got_eoi[k], k == 2);
    end
    check_bit(eoi_always_o, 1'b1);
    host_en <= 1'b0;
    wr(HSR_REG_CONFIG, 32'h48100);
    wr(HSR_REG_COUNT, 32'h2);
    wr(HSR_REG_CTRL, 32'h1);
    feed(32'hb1, taken);
    feed(32'hb2, taken);
    repeat (2) @(posedge clock_i);
    #1 check(out_data_o, 32'hb2);
    check_bit(out_full_o, 1'b1);
    host_en <= 1'b1;
    repeat (12) @(posedge clock_i);
    #1 check(32'(u_host.n_got), 32'h4);
    check(u_host.got_data[3], 32'hb2);
    check_bit(u_host.got_eoi[3], 1'b1);
    host_delay <= 4'h0;
  endtask
  task automatic t_fifo();
    logic taken;
    do_reset();
    wr(HSR_REG_CONFIG, 32'h44800);
    wr(HSR_REG_COUNT, 32'h64);
    wr(HSR_REG_CTRL, 32'h1);
    wr(HSR_REG_COUNT, 32'h5);
    for (int i = 0; i < 16; i++) begin
      feed(32'(i), taken);
    end
    #1 check_bit(fast_mode_o, 1'b1);
    feed(32'hee, taken);
    check_bit(taken, 1'b0);
    check_bit(fast_mode_o, 1'b0);
    rd_reg(HSR_REG_ARM);
    check(rd, {30'h0, HSR_ARM_HOLD});
    rd_reg(HSR_REG_COUNT);
    check(rd, 32'h64);
    rd_reg(HSR_REG_STATUS);
    check({26'h0, rd[9:4]}, 32'h21);
    wr(HSR_REG_CTRL, 32'h1);
    #1 check_bit(fast_mode_o, 1'b0);
    pop_mem();
    check(mem_data_o, 32'h0);
    wr(HSR_REG_ARM, {30'h0, HSR_ARM_AUTO});
    wr(HSR_REG_CTRL, 32'h1);
    #1 check_bit(fast_mode_o, 1'b1);
    check_bit(meas_run_o, 1'b1);
    pulse_clear();
    #1 check_bit(fast_mode_o, 1'b0);
    check_bit(meas_run_o, 1'b0);
  endtask
  task automatic t_lifo();
    logic taken;
    do_reset();
    wr(HSR_REG_CONFIG, 32'h41900);
    wr(HSR_REG_COUNT, 32'h14);
    wr(HSR_REG_CTRL, 32'h1);
    for (int i = 1; i <= 18; i++) begin
      feed(32'(i), taken);
      check_bit(taken, 1'b1);
    end
    for (int k = 0; k < 16; k++) begin
      pop_mem();
      check(mem_data_o, 32'(k + 3));
    end
  endtask
  task automatic t_preset();
    do_reset();
    wr(HSR_REG_CONFIG, 32'h40700);
    wr(HSR_REG_CTRL, 32'h2);
    rd_reg(HSR_REG_CONFIG);
    check(rd & 32'h1e700, 32'h14000);
    wr(HSR_REG_CTRL, 32'h1);
    #1 check_bit(fast_mode_o, 1'b1);
    pulse_clear();
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic results();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_entry();
    t_flow();
    t_fifo();
    t_lifo();
    t_preset();
    results();
  end
endmodule
